// ### verilog/dqt_defines.svh
`ifndef DQT_DEFINES_SVH
`define DQT_DEFINES_SVH

// Burst and FIFO geometry
`define DQT_BURST_LEN 16
`define DQT_BEAT_W 4
`define DQT_BEAT_LAST 4'hf
`define DQT_BYTE_SEL_BIT 3
`define DQT_FIFO_DEPTH 5
`define DQT_PTR_W 3
`define DQT_PTR_LAST 3'h4
`define DQT_DQ_W 16
`define DQT_DMI_W 2
`define DQT_LANES 18
`define DQT_MEM_WORDS 80
`define DQT_MEM_AW 7

// Command codes on the command pins
`define DQT_CMD_W 4
`define DQT_CMD_DES 4'h0
`define DQT_CMD_MPC 4'h1
`define DQT_CMD_CAS2 4'h2
`define DQT_CMD_WRITE 4'h3
`define DQT_CMD_MWRITE 4'h4
`define DQT_CMD_READ 4'h5
`define DQT_CMD_MRR 4'h6
`define DQT_CMD_PDE 4'h7
`define DQT_CMD_SRPDE 4'h8
`define DQT_CMD_CKEL 4'h9

// Multi-purpose command operand
`define DQT_OP_W 7
`define DQT_OP_EN_BIT 6
`define DQT_FN_RD_FIFO 6'h01
`define DQT_FN_RD_CAL 6'h02
`define DQT_FN_WR_FIFO 6'h03

// Register port
`define DQT_RA_W 4
`define DQT_RD_W 8
`define DQT_REG_PAT_FIRST 4'h0
`define DQT_REG_PAT_SECOND 4'h1
`define DQT_REG_MASK0 4'h2
`define DQT_REG_MASK1 4'h3
`define DQT_REG_MODE 4'h4
`define DQT_REG_LAT 4'h5
`define DQT_REG_STATUS 4'h6

// Reset values
`define DQT_RST_PAT_FIRST 8'h5a
`define DQT_RST_PAT_SECOND 8'h3c
`define DQT_RST_MASK 8'h55
`define DQT_RST_MODE 3'h1
`define DQT_RST_RL 4'h6
`define DQT_RST_WL 4'h4

// Field positions
`define DQT_MODE_DM_DIS 0
`define DQT_MODE_WBI 1
`define DQT_MODE_RBI 2
`define DQT_ST_DISTURB 7
`define DQT_ST_BUSY 6

`endif

// ### verilog/dqt_pkg.sv
`include "dqt_defines.svh"

package dqt_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_WBURST,
        ST_OBURST
    } dqt_state_e;

    // Training function in progress
    typedef enum logic [1:0] {
        FN_NONE,
        FN_WR_FIFO,
        FN_RD_FIFO,
        FN_RD_CAL
    } dqt_fn_e;

    // Whole state of the training block
    typedef struct packed {
        logic [`DQT_CMD_W-1:0] sy1_cmd;
        logic [`DQT_OP_W-1:0] sy1_op;
        logic [`DQT_LANES-1:0] sy1_dq;
        logic [`DQT_CMD_W-1:0] sy2_cmd;
        logic [`DQT_OP_W-1:0] sy2_op;
        logic [`DQT_LANES-1:0] sy2_dq;
        logic [7:0] pat_first;
        logic [7:0] pat_second;
        logic [7:0] mask0;
        logic [7:0] mask1;
        logic [2:0] mode;
        logic [3:0] rl;
        logic [3:0] wl;
        dqt_state_e state;
        dqt_fn_e fn;
        logic pend;
        logic [3:0] cnt;
        logic [`DQT_BEAT_W-1:0] beat;
        logic [`DQT_PTR_W-1:0] wr_ptr;
        logic [`DQT_PTR_W-1:0] rd_ptr;
        logic p1_v;
        logic p1_cal;
        logic [`DQT_BEAT_W-1:0] p1_beat;
        logic out_cal;
        logic [`DQT_BEAT_W-1:0] out_beat;
        logic oe;
        logic [`DQT_DQ_W-1:0] dq_out;
        logic [`DQT_DMI_W-1:0] dmi_out;
        logic dmi_oe;
        logic disturbed;
        logic [`DQT_RD_W-1:0] rdata;
    } dqt_regs_s;

endpackage

// ### verilog/dqt_mem.sv
`timescale 1ns/10ps
`include "dqt_defines.svh"

// Training FIFO storage, one word per beat, registered read data
module dqt_mem #(
    parameter int W = `DQT_LANES,
    parameter int DEPTH = `DQT_MEM_WORDS,
    parameter int AW = `DQT_MEM_AW
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);

    // Array plus read register
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } dqt_mem_s;

    dqt_mem_s s; // Current state
    dqt_mem_s next_s; // Next state

    // Write one word, read one word into the output register
    always_comb
    begin
        next_s = s;
        if (we && (int'(waddr) < DEPTH))
        begin
            next_s.mem[waddr] = wdata;
        end
        // Out of range reads give zero, a valid level
        next_s.rdata = (int'(raddr) < DEPTH) ? s.mem[raddr] : '0;
    end

    // Zero at reset so unwritten entries read valid levels
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;

endmodule

// ### verilog/dqt_train.sv
`timescale 1ns/10ps
`include "dqt_defines.svh"

// How it works
// - Multi-purpose command with bit 6 low: nothing
// - Bit 6 high: low six bits pick function
// - FIFO write captured after write latency from CAS-2
// - Five write bursts of sixteen beats stored
// - FIFO read returned after read latency
// - FIFO reads never change stored data
// - Unwritten entries read valid undefined levels
// - Reads walk entries zero to four, wrap
// - Calibration sends first byte then second everywhere
// - Each pattern byte sent low bit first
// - Invert masks flip DQ lanes, never mask lanes
// - Mask lanes float only when all three disabled
// - No bus inversion on calibration output
// - Mask bit one inverts matching DQ lane
// - Power-down entries reset both FIFO pointers
// - FIFO commands advance pointers; reads advance both
module dqt_train (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command pins
    input wire logic [`DQT_CMD_W-1:0] cmd_code,
    input wire logic [`DQT_OP_W-1:0] cmd_op,
    // Data pins, DQ lanes
    input wire logic [`DQT_DQ_W-1:0] dq_in,
    output logic [`DQT_DQ_W-1:0] dq_out,
    output logic [`DQT_DQ_W-1:0] dq_oe,
    // Data pins, data mask / inversion lanes
    input wire logic [`DQT_DMI_W-1:0] data_mask_inversion_pin_in,
    output logic [`DQT_DMI_W-1:0] data_mask_inversion_pin_out,
    output logic [`DQT_DMI_W-1:0] data_mask_inversion_pin_oe,
    // Register port
    input wire logic [`DQT_RA_W-1:0] reg_addr,
    input wire logic [`DQT_RD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DQT_RD_W-1:0] reg_rdata
);

    dqt_pkg::dqt_regs_s s; // Current state
    dqt_pkg::dqt_regs_s next_s; // Next state

    // Decoded command, after the pin synchroniser
    logic c_mpc; // Multi-purpose command
    logic c_cas2; // CAS-2 command
    logic c_any; // Anything but deselect
    logic c_read; // Normal read
    logic c_pd; // Power-down or self refresh power-down entry
    logic c_disturb; // Commands that disturb the FIFO
    logic [5:0] c_fn; // Function select field

    // Mode bits by name
    logic data_mask_disable;
    logic write_bus_inversion_enable;
    logic read_bus_inversion_enable;
    logic dmi_drive; // Mask lanes carry data

    // Memory hookup
    logic mem_we;
    logic [`DQT_MEM_AW-1:0] mem_waddr;
    logic [`DQT_MEM_AW-1:0] mem_raddr;
    logic [`DQT_LANES-1:0] mem_rdata;

    // Modulo-five pointer step
    function automatic logic [`DQT_PTR_W-1:0] ptr_inc(
        input logic [`DQT_PTR_W-1:0] p
    );
        return (p == `DQT_PTR_LAST) ? '0 : p + 3'h1;
    endfunction

    // Calibration bit for a beat: first byte, then second, low bit first
    function automatic logic cal_bit(
        input logic [7:0] first,
        input logic [7:0] second,
        input logic [`DQT_BEAT_W-1:0] k
    );
        logic [7:0] byte_sel;
        byte_sel = k[`DQT_BYTE_SEL_BIT] ? second : first;
        return byte_sel[k[2:0]];
    endfunction

    // Command decode
    assign c_any = (s.sy2_cmd != `DQT_CMD_DES);
    assign c_mpc = (s.sy2_cmd == `DQT_CMD_MPC);
    assign c_cas2 = (s.sy2_cmd == `DQT_CMD_CAS2);
    assign c_read = (s.sy2_cmd == `DQT_CMD_READ);
    assign c_pd = (s.sy2_cmd == `DQT_CMD_PDE) ||
                  (s.sy2_cmd == `DQT_CMD_SRPDE);
    assign c_disturb = (s.sy2_cmd == `DQT_CMD_WRITE) ||
                       (s.sy2_cmd == `DQT_CMD_MWRITE) ||
                       c_read ||
                       (s.sy2_cmd == `DQT_CMD_MRR) ||
                       (s.sy2_cmd == `DQT_CMD_CKEL);
    assign c_fn = s.sy2_op[5:0];

    // Mask lanes float only with mask off and both inversions off
    assign data_mask_disable = s.mode[`DQT_MODE_DM_DIS];
    assign write_bus_inversion_enable = s.mode[`DQT_MODE_WBI];
    assign read_bus_inversion_enable = s.mode[`DQT_MODE_RBI];
    assign dmi_drive = !data_mask_disable || write_bus_inversion_enable ||
                       read_bus_inversion_enable;

    // FIFO storage addressing: entry in the high bits, beat in the low
    assign mem_we = (s.state == dqt_pkg::ST_WBURST);
    assign mem_waddr = {s.wr_ptr, s.beat};
    assign mem_raddr = {s.rd_ptr, s.beat};

    // Training FIFO, five sixteen-beat entries over all lanes
    dqt_mem #(
        .W(`DQT_LANES),
        .DEPTH(`DQT_MEM_WORDS),
        .AW(`DQT_MEM_AW)
    ) u_mem (
        .clk(clk),
        .rstn(rstn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(s.sy2_dq),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // Next-state logic for the whole block
    always_comb
    begin
        next_s = s;
        // Two-stage synchronisers on all pins
        next_s.sy1_cmd = cmd_code;
        next_s.sy1_op = cmd_op;
        next_s.sy1_dq = {data_mask_inversion_pin_in, dq_in};
        next_s.sy2_cmd = s.sy1_cmd;
        next_s.sy2_op = s.sy1_op;
        next_s.sy2_dq = s.sy1_dq;

        // Register reads, answer in the next cycle
        next_s.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                `DQT_REG_PAT_FIRST: next_s.rdata = s.pat_first;
                `DQT_REG_PAT_SECOND: next_s.rdata = s.pat_second;
                `DQT_REG_MASK0: next_s.rdata = s.mask0;
                `DQT_REG_MASK1: next_s.rdata = s.mask1;
                `DQT_REG_MODE: next_s.rdata = {5'h00, s.mode};
                `DQT_REG_LAT: next_s.rdata = {s.wl, s.rl};
                `DQT_REG_STATUS: next_s.rdata = {s.disturbed,
                    (s.state != dqt_pkg::ST_IDLE), s.rd_ptr, s.wr_ptr};
                // Unmapped addresses read zero
                default: next_s.rdata = '0;
            endcase
        end

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `DQT_REG_PAT_FIRST: next_s.pat_first = reg_wdata;
                `DQT_REG_PAT_SECOND: next_s.pat_second = reg_wdata;
                `DQT_REG_MASK0: next_s.mask0 = reg_wdata;
                `DQT_REG_MASK1: next_s.mask1 = reg_wdata;
                `DQT_REG_MODE: next_s.mode = reg_wdata[2:0];
                `DQT_REG_LAT:
                begin
                    next_s.rl = reg_wdata[3:0];
                    next_s.wl = reg_wdata[7:4];
                end
                // Write one to clear the disturbed flag
                `DQT_REG_STATUS:
                begin
                    if (reg_wdata[`DQT_ST_DISTURB])
                    begin
                        next_s.disturbed = 1'b0;
                    end
                end
                // Other addresses ignore writes
                default: ;
            endcase
        end

        // Disturbing commands flag the FIFO, winning over a clear
        if (c_disturb)
        begin
            next_s.disturbed = 1'b1;
        end

        // Any command ends a waiting training command
        if (c_any)
        begin
            next_s.pend = 1'b0;
        end

        // Sequencer
        unique case (s.state)
            dqt_pkg::ST_IDLE:
            begin
                if (s.pend && c_cas2)
                begin
                    // Latency counted from the CAS-2 command
                    next_s.state = dqt_pkg::ST_WAIT;
                    next_s.cnt = (s.fn == dqt_pkg::FN_WR_FIFO) ?
                                 s.wl : s.rl;
                    if (s.fn == dqt_pkg::FN_RD_CAL)
                    begin
                        next_s.disturbed = 1'b1;
                    end
                end
                else if (c_mpc && s.sy2_op[`DQT_OP_EN_BIT])
                begin
                    // Bit 6 high: pick the function, reserved codes idle
                    next_s.pend = 1'b1;
                    unique case (c_fn)
                        `DQT_FN_WR_FIFO: next_s.fn = dqt_pkg::FN_WR_FIFO;
                        `DQT_FN_RD_FIFO: next_s.fn = dqt_pkg::FN_RD_FIFO;
                        `DQT_FN_RD_CAL: next_s.fn = dqt_pkg::FN_RD_CAL;
                        default:
                        begin
                            next_s.fn = dqt_pkg::FN_NONE;
                            next_s.pend = 1'b0;
                        end
                    endcase
                end
                // Bit 6 low is a no-operation: nothing is armed
                else if (c_mpc)
                begin
                    next_s.fn = dqt_pkg::FN_NONE;
                end
            end
            dqt_pkg::ST_WAIT:
            begin
                // Count the latency down, then start the burst
                if (s.cnt == 4'h0)
                begin
                    next_s.beat = '0;
                    next_s.state = (s.fn == dqt_pkg::FN_WR_FIFO) ?
                                   dqt_pkg::ST_WBURST : dqt_pkg::ST_OBURST;
                end
                else
                begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            dqt_pkg::ST_WBURST:
            begin
                // One beat per cycle into the entry at the write pointer
                next_s.beat = s.beat + 4'h1;
                if (s.beat == `DQT_BEAT_LAST)
                begin
                    next_s.wr_ptr = ptr_inc(s.wr_ptr);
                    next_s.state = dqt_pkg::ST_IDLE;
                    next_s.fn = dqt_pkg::FN_NONE;
                end
            end
            dqt_pkg::ST_OBURST:
            begin
                // Issue one beat per cycle to the output pipeline
                next_s.beat = s.beat + 4'h1;
                if (s.beat == `DQT_BEAT_LAST)
                begin
                    if (s.fn == dqt_pkg::FN_RD_FIFO)
                    begin
                        // Wraps four to zero, written or not
                        next_s.rd_ptr = ptr_inc(s.rd_ptr);
                    end
                    next_s.state = dqt_pkg::ST_IDLE;
                    next_s.fn = dqt_pkg::FN_NONE;
                end
            end
        endcase

        // Normal read moves both pointers
        if (c_read)
        begin
            next_s.wr_ptr = ptr_inc(next_s.wr_ptr);
            next_s.rd_ptr = ptr_inc(next_s.rd_ptr);
        end

        // Power-down entries restart both pointers
        if (c_pd)
        begin
            next_s.wr_ptr = '0;
            next_s.rd_ptr = '0;
        end

        // Output pipeline: memory read stage, then pin register
        next_s.p1_v = (s.state == dqt_pkg::ST_OBURST);
        next_s.p1_cal = (s.fn == dqt_pkg::FN_RD_CAL);
        next_s.p1_beat = s.beat;
        next_s.oe = s.p1_v;
        next_s.out_cal = s.p1_cal;
        next_s.out_beat = s.p1_beat;
        next_s.dmi_oe = s.p1_v && dmi_drive;
        if (s.p1_cal)
        begin
            // Same bit on every lane, DQ flipped by mask, no inversion
            next_s.dq_out = {`DQT_DQ_W{cal_bit(s.pat_first,
                s.pat_second, s.p1_beat)}} ^
                {s.mask1, s.mask0};
            next_s.dmi_out = {`DQT_DMI_W{cal_bit(s.pat_first,
                s.pat_second, s.p1_beat)}};
        end
        else
        begin
            // Stored beat, unchanged by the read
            next_s.dq_out = mem_rdata[`DQT_DQ_W-1:0];
            next_s.dmi_out = mem_rdata[`DQT_LANES-1:`DQT_DQ_W];
        end
    end

    // State register with reset values
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.pat_first <= `DQT_RST_PAT_FIRST;
            s.pat_second <= `DQT_RST_PAT_SECOND;
            s.mask0 <= `DQT_RST_MASK;
            s.mask1 <= `DQT_RST_MASK;
            s.mode <= `DQT_RST_MODE;
            s.rl <= `DQT_RST_RL;
            s.wl <= `DQT_RST_WL;
            s.state <= dqt_pkg::ST_IDLE;
            s.fn <= dqt_pkg::FN_NONE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Pin and register outputs, all from flops
    assign dq_out = s.dq_out;
    assign dq_oe = {`DQT_DQ_W{s.oe}};
    assign data_mask_inversion_pin_out = s.dmi_out;
    assign data_mask_inversion_pin_oe = {`DQT_DMI_W{s.dmi_oe}};
    assign reg_rdata = s.rdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_nop_arms_nothing: assert property (
        (s.state == dqt_pkg::ST_IDLE && !s.pend && c_mpc &&
         !s.sy2_op[`DQT_OP_EN_BIT]) |=> !s.pend ##1
        (s.state == dqt_pkg::ST_IDLE))
        else $error("no-operation command armed a function");

    a_func_armed: assert property (
        (s.state == dqt_pkg::ST_IDLE && !s.pend && c_mpc &&
         s.sy2_op[`DQT_OP_EN_BIT] && c_fn == `DQT_FN_RD_CAL) |=>
        (s.pend && s.fn == dqt_pkg::FN_RD_CAL))
        else $error("calibration function not armed");

    a_lat_load: assert property (
        (s.state == dqt_pkg::ST_IDLE && s.pend && c_cas2 &&
         s.fn != dqt_pkg::FN_WR_FIFO) |=>
        (s.state == dqt_pkg::ST_WAIT && s.cnt == $past(s.rl)))
        else $error("read latency not loaded");

    a_burst_length: assert property (
        $rose(s.oe) |-> s.oe [*8] ##1 s.oe [*8] ##1 !s.oe)
        else $error("output burst is not sixteen beats");

    a_cal_invert: assert property (
        (s.oe && s.out_cal) |->
        ((s.dq_out ^ $past({s.mask1, s.mask0})) ==
         {`DQT_DQ_W{s.dmi_out[0]}} && s.dmi_out[1] == s.dmi_out[0]))
        else $error("calibration inversion wrong");

    a_cal_order: assert property (
        (s.oe && s.out_cal && $stable(s.pat_first) &&
         $stable(s.pat_second)) |->
        (s.dmi_out[0] == cal_bit(s.pat_first, s.pat_second,
         s.out_beat)))
        else $error("calibration bit order wrong");

    a_dmi_hiz: assert property (
        s.oe |-> (s.dmi_oe == $past(dmi_drive)))
        else $error("mask lane drive wrong");

    a_rd_wrap: assert property (
        (s.state == dqt_pkg::ST_OBURST && s.fn == dqt_pkg::FN_RD_FIFO &&
         s.beat == `DQT_BEAT_LAST && s.rd_ptr == `DQT_PTR_LAST &&
         !c_read && !c_pd) |=> (s.rd_ptr == '0))
        else $error("read pointer did not wrap");

    a_ptr_reset: assert property (
        c_pd |=> (s.wr_ptr == '0 && s.rd_ptr == '0))
        else $error("pointers not reset on power-down entry");

    a_read_both: assert property (
        (c_read && s.state == dqt_pkg::ST_IDLE && !c_pd) |=>
        (s.wr_ptr == ptr_inc($past(s.wr_ptr)) &&
         s.rd_ptr == ptr_inc($past(s.rd_ptr))))
        else $error("normal read did not move both pointers");

    a_rd_keeps: assert property (
        (s.state == dqt_pkg::ST_OBURST) |-> !mem_we)
        else $error("FIFO written during read burst");

endmodule

// ### tb/dqt_ctrl_model.sv
`timescale 1ns/10ps
`include "dqt_defines.svh"

// Controller side: training commands and write burst data
module dqt_ctrl_model #(
    // Cycles held off after power-down before calibration may follow
    parameter int powerdown_exit_cal_delay = 8
) (
    // Clock
    input wire logic clk,
    // Command pins
    output logic [3:0] cmd_code,
    output logic [6:0] cmd_op,
    // Data lanes toward the device
    output logic [15:0] dq_in,
    output logic [1:0] mask_in
);
    // Idle pins at time zero
    initial
    begin
        cmd_code = `DQT_CMD_DES;
        cmd_op = 7'h00;
        dq_in = 16'h0000;
        mask_in = 2'h0;
    end

    // One plain command, then deselect and let it settle
    task automatic one_cmd(input logic [3:0] c);
        @(posedge clk);
        cmd_code <= c;
        @(posedge clk);
        cmd_code <= `DQT_CMD_DES;
        repeat (3) @(posedge clk);
        // Leaving power-down: wait before any calibration command
        if (c == `DQT_CMD_PDE || c == `DQT_CMD_SRPDE)
            repeat (powerdown_exit_cal_delay) @(posedge clk);
    endtask

    // Multi-purpose command directly followed by CAS-2
    task automatic mpc(input logic [6:0] op);
        @(posedge clk);
        cmd_code <= `DQT_CMD_MPC;
        cmd_op <= op;
        @(posedge clk);
        cmd_code <= `DQT_CMD_CAS2;
        cmd_op <= 7'h00;
        @(posedge clk);
        cmd_code <= `DQT_CMD_DES;
    endtask

    // Write burst for entry n; released lines show the inverse
    task automatic wr_fifo(input int n);
        mpc({1'b1, `DQT_FN_WR_FIFO});
        repeat (`DQT_RST_WL + 1) @(posedge clk);
        for (int k = 0; k < 16; k++)
        begin
            // Held the whole beat, captured on the edge that launches the next beat
            dq_in <= 16'(16'h1111 * (n + 1) ^ k);
            mask_in <= 2'(n + k);
            @(posedge clk);
        end
        dq_in <= ~dq_in;
        mask_in <= ~mask_in;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### tb/dqt_train_tb.sv
`timescale 1ns/10ps
`include "dqt_defines.svh"

// Self-checking bench for the training block
module dqt_train_tb;
    logic clk;
    logic rstn;
    // Pins between controller model and block
    logic [3:0] cmd_code;
    logic [6:0] cmd_op;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
    logic [1:0] mask_in;
    logic [1:0] mask_out;
    logic [1:0] mask_oe;
    // Register port
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] rd;
    logic [7:0] rst_val [6] = '{8'h5a, 8'h3c, 8'h55, 8'h55,
                                8'h01, 8'h46};
    int mismatches;
    int compares;

    dqt_train dut_u (.clk(clk), .rstn(rstn), .cmd_code(cmd_code),
        .cmd_op(cmd_op), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .data_mask_inversion_pin_in(mask_in),
        .data_mask_inversion_pin_out(mask_out),
        .data_mask_inversion_pin_oe(mask_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    dqt_ctrl_model mdl_u (.clk(clk), .cmd_code(cmd_code), .cmd_op(cmd_op),
        .dq_in(dq_in), .mask_in(mask_in));

    // Compare and count
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register write, one strobe cycle
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Register read, data taken in the following cycle
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    // Calibration burst against pattern, masks and mask lane drive
    task automatic run_cal(input logic [7:0] f, input logic [7:0] s,
                           input logic [15:0] m, input logic drv,
                           input int lat);
        logic b;
        mdl_u.mpc({1'b1, `DQT_FN_RD_CAL});
        repeat (lat + 5) @(posedge clk);
        for (int k = 0; k < 16; k++)
        begin
            #1;
            b = (k < 8) ? f[k] : s[k - 8];
            check(dq_out, {16{b}} ^ m);
            check(dq_oe, 16'hffff);
            check(mask_oe, {2{drv}});
            if (drv)
                check(mask_out, {2{b}});
            @(posedge clk);
        end
        #1;
        check(dq_oe, 16'h0000);
    endtask

    // Disabled and reserved operands start nothing
    task automatic run_nop();
        mdl_u.mpc(7'h02);
        mdl_u.mpc(7'h7f);
        repeat (30)
        begin
            @(posedge clk);
            #1;
            check(dq_oe, 16'h0000);
        end
    endtask

    // One FIFO read burst; entry e written, or still at reset level
    task automatic read_entry(input int e, input logic wr);
        logic [15:0] d;
        mdl_u.mpc({1'b1, `DQT_FN_RD_FIFO});
        repeat (`DQT_RST_RL + 5) @(posedge clk);
        for (int k = 0; k < 16; k++)
        begin
            #1;
            d = wr ? 16'(16'h1111 * (e + 1) ^ k) : 16'h0000;
            check(dq_out, d);
            check(mask_out, wr ? 2'(e + k) : 2'h0);
            @(posedge clk);
        end
    endtask

    // Unwritten read, five writes, six reads with wrap, pointer effects
    task automatic run_fifo();
        read_entry(0, 1'b0);
        mdl_u.one_cmd(`DQT_CMD_SRPDE);
        for (int n = 0; n < 5; n++)
            mdl_u.wr_fifo(n);
        for (int r = 0; r < 6; r++)
            read_entry(r % 5, 1'b1);
        reg_read(4'h6);
        check(rd, 8'h88);
        mdl_u.one_cmd(`DQT_CMD_PDE);
        reg_read(4'h6);
        check(rd, 8'h80);
        mdl_u.one_cmd(`DQT_CMD_READ);
        reg_read(4'h6);
        check(rd, 8'h89);
        reg_write(4'h6, 8'h80);
        reg_read(4'h6);
        check(rd, 8'h09);
        mdl_u.one_cmd(`DQT_CMD_CKEL);
        reg_read(4'h6);
        check(rd, 8'h89);
    endtask

    // Report and end the run
    task automatic complete_run();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, far beyond the expected run
    initial
    begin
        #50000;
        mismatches++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        foreach (rst_val[i])
        begin
            reg_read(4'(i));
            check(rd, rst_val[i]);
        end
        reg_write(4'hf, 8'hff);
        reg_read(4'hf);
        check(rd, 8'h00);
        run_cal(8'h5a, 8'h3c, 16'h5555, 1'b0, `DQT_RST_RL);
        reg_write(4'h0, 8'h1c);
        reg_write(4'h1, 8'h59);
        reg_write(4'h3, 8'h0f);
        for (int m = 0; m < 8; m++)
        begin
            reg_write(4'h4, 8'(m));
            run_cal(8'h1c, 8'h59, 16'h0f55, m != 1, `DQT_RST_RL);
        end
        reg_write(4'h5, 8'h42);
        run_cal(8'h1c, 8'h59, 16'h0f55, 1'b1, 2);
        reg_write(4'h5, 8'h46);
        run_nop();
        run_fifo();
        complete_run();
    end
endmodule
